// ==== tes_pkg.sv ====
// package of the transmitter edge shaping block: register map, fields,
// codes, reset values and the bus carrier types.
// assumes one 100 MHz clock and an 8-bit register port on that clock.
package tes_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_RESID_212 = 8'h18;
  localparam logic [7:0] OFS_KIND_212 = 8'h19;
  localparam logic [7:0] OFS_PARAM_212 = 8'h1a;
  localparam logic [7:0] OFS_DUR_212 = 8'h1b;
  localparam logic [7:0] OFS_RESID_424 = 8'h1c;
  localparam logic [7:0] OFS_KIND_424 = 8'h1d;
  localparam logic [7:0] OFS_LUT_INDEX = 8'h30;
  localparam logic [7:0] OFS_LUT_DATA = 8'h31;
  localparam logic [7:0] OFS_STATUS = 8'h32;

  // ==========================================================
  // field positions and masks
  localparam int FALL_LSB = 4;
  localparam int FIELD_MSB_KIND = 3;
  localparam int PARAM_FALL_LSB = 4;
  localparam int DUR_STRETCH_BIT = 7;
  localparam logic [7:0] PARAM_MASK = 8'h77;
  localparam logic [7:0] DUR_MASK = 8'h9f;
  localparam logic [7:0] LUT_INDEX_MASK = 8'h7f;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_RESID_212 = 8'h00;
  localparam logic [7:0] RST_KIND_212 = 8'h00;
  localparam logic [7:0] RST_PARAM_212 = 8'h00;
  localparam logic [7:0] RST_DUR_212 = 8'h00;
  localparam logic [7:0] RST_RESID_424 = 8'h00;
  localparam logic [7:0] RST_KIND_424 = 8'h00;
  localparam logic [7:0] AMP_FULL = 8'hff;

  // ==========================================================
  // edge shape kind codes, one nibble per edge
  localparam logic [3:0] KIND_FW_ONE = 4'h1;
  localparam logic [3:0] KIND_FW_TWO = 4'h2;
  localparam logic [3:0] KIND_FW_THREE = 4'h3;
  localparam logic [3:0] KIND_LUT_PLAIN = 4'h4;
  localparam logic [3:0] KIND_LUT_CORR = 4'h5;
  localparam logic [3:0] KIND_LUT_ADAPT = 4'h6;

  // ==========================================================
  // lookup table geometry: four tables of 32 entries
  localparam int NUM_LUTS = 4;
  localparam int LUT_ENTRIES = 32;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tes_bus_req_t;

  // carrier amplitude state machine
  typedef enum logic [1:0] {ST_FULL, ST_FALL, ST_LOW, ST_RISE} tes_state_t;

endpackage

// ==== tes_lut_mem.sv ====
// edge lookup table memory: one write port, one registered read port.
// assumes both ports on clk; contents are undefined until software loads them.
`timescale 1ns/10ps
module tes_lut_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("tes_lut_mem: DEPTH must be a power of two");
  end

  // ==========================================================
  // storage write
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // tes_lut_mem

// ==== tes_state_timer.sv ====
// transition state timer: counts carrier ticks into edge states.
// assumes carrier_tick is a one-cycle pulse from logic on the same clock.
`timescale 1ns/10ps
module tes_state_timer #(
  parameter int CNT_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic tick,
  input wire logic stretch,
  input wire logic [CNT_W-1:0] count,
  output logic [CNT_W-1:0] idx,
  output logic [CNT_W-1:0] done_idx,
  output logic step,
  output logic last,
  output logic busy
);
  logic half;
  logic stretch_q;
  logic [CNT_W-1:0] count_q;

  if (CNT_W < 1 || CNT_W > 8) begin : g_chk
    $error("tes_state_timer: CNT_W must be 1 to 8");
  end

  // ==========================================================
  // one or two ticks per state, count states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      half <= 1'b0;
      idx <= '0;
      done_idx <= '0;
      step <= 1'b0;
      last <= 1'b0;
      stretch_q <= 1'b0;
      count_q <= '0;
    end else begin
      step <= 1'b0;
      last <= 1'b0;
      if (start) begin
        busy <= (count != '0);
        half <= 1'b0;
        idx <= '0;
        stretch_q <= stretch;
        count_q <= count;
      end else if (busy && tick) begin
        if (stretch_q && !half) begin
          half <= 1'b1; // first carrier cycle of a doubled state
        end else begin
          half <= 1'b0;
          step <= 1'b1;
          done_idx <= idx;
          if (idx == count_q - 1'b1) begin
            busy <= 1'b0;
            last <= 1'b1;
          end else begin
            idx <= idx + 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // checks
  // single and doubled state lengths, end at the state count
  unit_state_a: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && tick && !start && !stretch_q) |=> step)
    else $error("state did not end on its carrier tick");
  double_state_a: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && tick && !start && stretch_q && !half) |=> !step ##0 half)
    else $error("doubled state ended after one carrier cycle");
  count_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    step |-> (last == (done_idx == count_q - 1'b1)))
    else $error("edge did not end at the programmed state count");
endmodule // tes_state_timer

// ==== tes_top.sv ====
// transmitter modulation edge shaping for the 212 kbit/s rate, with the
// 424 kbit/s residual level and edge kind held for the next stage.
// assumes same-clock mod_req, carrier_tick and power_amp_supply inputs.
//
// Operation
// - falling edge kind from upper nibble
// - code 4: table ramp, no supply adaptation
// - code 5: table ramp, adapted, with correction
// - code 6: table ramp, adapted, no correction
// - rising edge kind from lower nibble
// - falling field is firmware time constant
// - falling field selects table 0 to 3
// - rising field is firmware time constant
// - rising field selects table 0 to 3
// - stretch clear: state lasts one carrier
// - stretch set: state lasts two carriers
// - state count shared by both edges
// - 424k residual level, 00 zero, ff full
`timescale 1ns/10ps
module tes_top (
  input wire logic clk,
  input wire logic rst_n,
  input tes_pkg::tes_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic mod_req,
  input wire logic carrier_tick,
  input wire logic [7:0] power_amp_supply,
  output logic [7:0] amplitude,
  output logic edge_active,
  output logic [7:0] residual_level_424k,
  output logic [7:0] shape_kind_424k
);
  import tes_pkg::*;

  logic rst_meta_n;
  logic rst_sync_n;
  logic [7:0] residual_carrier_212k;
  logic [7:0] edge_shape_kind_212k;
  logic [7:0] edge_shape_param_212k;
  logic [7:0] edge_duration_212k;
  logic [6:0] lut_index;
  tes_state_t state;
  logic falling_q;
  logic [3:0] kind_q;
  logic [2:0] sel_q;
  logic [4:0] cnt_q;
  logic [7:0] start_q;
  logic [7:0] target_q;
  logic [7:0] delta_q;
  logic next_start;
  logic next_falling;
  logic [3:0] next_kind;
  logic next_now;
  logic [7:0] next_target;
  logic [4:0] t_idx;
  logic [4:0] t_done;
  logic t_step;
  logic t_last;
  logic t_busy;
  logic [7:0] lut_data;
  logic is_fw;
  logic is_lut;
  logic [7:0] base_step;
  logic [7:0] seg_step;
  logic [4:0] mark_half;
  logic [4:0] mark_three_q;
  logic [15:0] adapt_prod;
  logic [7:0] frac;
  logic [15:0] off_prod;
  logic [7:0] lut_amp;
  logic [7:0] fw_amp;
  logic [7:0] next_amp;

  // ==========================================================
  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // register writes
  // reserved bits masked on write
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      residual_carrier_212k <= RST_RESID_212;
      edge_shape_kind_212k <= RST_KIND_212;
      edge_shape_param_212k <= RST_PARAM_212;
      edge_duration_212k <= RST_DUR_212;
      residual_level_424k <= RST_RESID_424;
      shape_kind_424k <= RST_KIND_424;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_RESID_212: residual_carrier_212k <= bus_req.wdata;
        OFS_KIND_212: edge_shape_kind_212k <= bus_req.wdata;
        OFS_PARAM_212: edge_shape_param_212k <= bus_req.wdata & PARAM_MASK;
        OFS_DUR_212: edge_duration_212k <= bus_req.wdata & DUR_MASK;
        OFS_RESID_424: residual_level_424k <= bus_req.wdata;
        OFS_KIND_424: shape_kind_424k <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // table pointer, steps on each table data write
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lut_index <= '0;
    end else if (bus_req.wr && bus_req.addr == OFS_LUT_INDEX) begin
      lut_index <= bus_req.wdata[6:0];
    end else if (bus_req.wr && bus_req.addr == OFS_LUT_DATA) begin
      lut_index <= lut_index + 7'h01;
    end
  end

  // register reads, data in the next cycle; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_RESID_212: rdata <= residual_carrier_212k;
        OFS_KIND_212: rdata <= edge_shape_kind_212k;
        OFS_PARAM_212: rdata <= edge_shape_param_212k;
        OFS_DUR_212: rdata <= edge_duration_212k;
        OFS_RESID_424: rdata <= residual_level_424k;
        OFS_KIND_424: rdata <= shape_kind_424k;
        OFS_LUT_INDEX: rdata <= {1'b0, lut_index};
        OFS_STATUS: rdata <= {t_busy, state, t_idx};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================================
  // edge launch decode
  // falling kind upper nibble, rising kind lower nibble
  always_comb begin
    next_start = (state == ST_FULL && mod_req) || (state == ST_LOW && !mod_req);
    next_falling = (state == ST_FULL);
    next_kind = next_falling ? edge_shape_kind_212k[7:FALL_LSB]
                             : edge_shape_kind_212k[FIELD_MSB_KIND:0];
    next_target = next_falling ? residual_carrier_212k : AMP_FULL;
    // reserved kinds and a zero count switch the level at once
    next_now = (next_kind < KIND_FW_ONE) || (next_kind > KIND_LUT_ADAPT) ||
               (edge_duration_212k[4:0] == 5'h00);
  end

  // latch edge settings so writes during an edge cannot tear it
  // falling field, rising field
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      falling_q <= 1'b0;
      kind_q <= 4'h0;
      sel_q <= 3'h0;
      cnt_q <= 5'h00;
      start_q <= AMP_FULL;
      target_q <= AMP_FULL;
      delta_q <= 8'h00;
    end else if (next_start) begin
      falling_q <= next_falling;
      kind_q <= next_kind;
      sel_q <= next_falling ? edge_shape_param_212k[6:PARAM_FALL_LSB]
                            : edge_shape_param_212k[2:0];
      cnt_q <= edge_duration_212k[4:0];
      start_q <= amplitude;
      target_q <= next_target;
      delta_q <= next_falling ? amplitude - next_target : next_target - amplitude;
    end
  end

  // ==========================================================
  // state sequencing and lookup table
  tes_state_timer #(
    .CNT_W(5)
  ) i_tes_state_timer (
    .clk(clk),
    .rst_n(rst_sync_n),
    .start(next_start && !next_now),
    .tick(carrier_tick),
    .stretch(edge_duration_212k[DUR_STRETCH_BIT]),
    .count(edge_duration_212k[4:0]),
    .idx(t_idx),
    .done_idx(t_done),
    .step(t_step),
    .last(t_last),
    .busy(t_busy)
  );

  tes_lut_mem #(
    .WIDTH(8),
    .DEPTH(NUM_LUTS * LUT_ENTRIES)
  ) i_tes_lut_mem (
    .clk(clk),
    .rst_n(rst_sync_n),
    .wr_en(bus_req.wr && bus_req.addr == OFS_LUT_DATA),
    .wr_addr(lut_index),
    .wr_data(bus_req.wdata),
    .rd_addr({sel_q[1:0], t_idx}),
    .rd_data(lut_data)
  );

  // ==========================================================
  // amplitude of the state just ended
  always_comb begin
    is_fw = (kind_q >= KIND_FW_ONE) && (kind_q <= KIND_FW_THREE);
    is_lut = (kind_q >= KIND_LUT_PLAIN) && (kind_q <= KIND_LUT_ADAPT);
    // time constant sets the step size
    base_step = delta_q >> sel_q;
    if (base_step == 8'h00) begin
      base_step = 8'h01;
    end
    mark_half = {1'b0, cnt_q[4:1]};
    mark_three_q = mark_half + {2'b00, cnt_q[4:2]};
    // one, two or three linear segments
    seg_step = base_step;
    if (kind_q == KIND_FW_TWO && t_done >= mark_half) begin
      seg_step = base_step >> 1;
    end else if (kind_q == KIND_FW_THREE && t_done >= mark_three_q) begin
      seg_step = base_step >> 2;
    end else if (kind_q == KIND_FW_THREE && t_done >= mark_half) begin
      seg_step = base_step >> 1;
    end
    if (seg_step == 8'h00) begin
      seg_step = 8'h01;
    end
    if (falling_q) begin
      fw_amp = (amplitude - target_q <= seg_step) ? target_q : amplitude - seg_step;
    end else begin
      fw_amp = (target_q - amplitude <= seg_step) ? target_q : amplitude + seg_step;
    end
    adapt_prod = lut_data * power_amp_supply;
    frac = (kind_q == KIND_LUT_PLAIN) ? lut_data : adapt_prod[15:8];
    off_prod = delta_q * frac;
    lut_amp = falling_q ? start_q - off_prod[15:8] : start_q + off_prod[15:8];
    // correction lands the last state on target
    if (t_last && (is_fw || kind_q == KIND_LUT_CORR)) begin
      next_amp = target_q;
    end else if (is_lut) begin
      next_amp = lut_amp;
    end else begin
      next_amp = fw_amp;
    end
  end

  // carrier amplitude output
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      amplitude <= AMP_FULL;
    end else if (next_start && next_now) begin
      amplitude <= next_target;
    end else if (t_step) begin
      amplitude <= next_amp;
    end
  end

  // ==========================================================
  // modulation state machine
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_FULL;
    end else begin
      case (state)
        ST_FULL: if (mod_req) state <= next_now ? ST_LOW : ST_FALL;
        ST_FALL: if (t_step && t_last) state <= ST_LOW;
        ST_LOW: if (!mod_req) state <= next_now ? ST_FULL : ST_RISE;
        ST_RISE: if (t_step && t_last) state <= ST_FULL;
        default: state <= ST_FULL;
      endcase
    end
  end

  // edge in progress flag
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      edge_active <= 1'b0;
    end else begin
      edge_active <= (next_start && !next_now) || (t_busy && !(t_step && t_last));
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  reserved_bits_a: assert property (
    $past(bus_req.rd && bus_req.addr == OFS_PARAM_212) |-> (rdata & ~PARAM_MASK) == 8'h00)
    else $error("reserved bits of edge style read nonzero");
  fall_kind_a: assert property (
    (state == ST_FULL && mod_req) |=> kind_q == $past(edge_shape_kind_212k[7:4]))
    else $error("falling edge did not take the upper nibble");
  rise_kind_a: assert property (
    (state == ST_LOW && !mod_req) |=> kind_q == $past(edge_shape_kind_212k[3:0]))
    else $error("rising edge did not take the lower nibble");
  table_sel_a: assert property (
    (state == ST_FULL && mod_req) |=> sel_q == $past(edge_shape_param_212k[6:4]))
    else $error("falling edge took the wrong table field");
  rise_sel_a: assert property (
    (state == ST_LOW && !mod_req) |=> sel_q == $past(edge_shape_param_212k[2:0]))
    else $error("rising edge took the wrong table field");
  fw_final_a: assert property (
    (t_step && t_last && is_fw) |=> amplitude == target_q)
    else $error("firmware ramp missed its target");
  lut_plain_a: assert property (
    (t_step && kind_q == KIND_LUT_PLAIN) |=>
      amplitude == $past(falling_q ? start_q - ((delta_q * {8'h00, lut_data}) >> 8)
                                   : start_q + ((delta_q * {8'h00, lut_data}) >> 8)))
    else $error("plain table ramp was altered");
  // corrected table edge ends on target
  adapt_corr_a: assert property (
    (t_step && t_last && kind_q == KIND_LUT_CORR) |=> amplitude == target_q)
    else $error("corrected table ramp missed its target");
  adapt_nocorr_a: assert property (
    (t_step && kind_q == KIND_LUT_ADAPT) |=> amplitude == $past(lut_amp))
    else $error("uncorrected table ramp was overwritten");
  resid_424_a: assert property (
    (bus_req.wr && bus_req.addr == OFS_RESID_424) |=> residual_level_424k == $past(bus_req.wdata))
    else $error("424k residual level not stored");

  fall_edge_c: cover property (state == ST_FALL ##1 state == ST_LOW);
  rise_edge_c: cover property (state == ST_RISE ##1 state == ST_FULL);
  lut_corr_c: cover property (t_step && t_last && kind_q == KIND_LUT_CORR);
endmodule // tes_top

// ==== tes_top_tb.sv ====
// self-checking testbench of the transmitter edge shaping block.
// assumes tes_pkg and all design modules are compiled first; one 100 MHz clock.
`timescale 1ns/10ps
module tes_top_tb;
  import tes_pkg::*;

  // ==========================================================
  // clock, reset and stimulus signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tes_bus_req_t bus_req = '0;
  logic mod_req = 1'b0;
  logic carrier_tick = 1'b0;
  logic [7:0] power_amp_supply = 8'h80;
  logic [7:0] rdata;
  logic [7:0] amplitude;
  logic edge_active;
  logic [7:0] residual_level_424k;
  logic [7:0] shape_kind_424k;
  int fails = 0;
  int num_checks = 0;

  // 10 ns period clock
  always #5 clk = ~clk;

  tes_top i_tes_top (
    .clk(clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .rdata(rdata),
    .mod_req(mod_req),
    .carrier_tick(carrier_tick),
    .power_amp_supply(power_amp_supply),
    .amplitude(amplitude),
    .edge_active(edge_active),
    .residual_level_424k(residual_level_424k),
    .shape_kind_424k(shape_kind_424k)
  );

  // ==========================================================
  // compare and bus tasks
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // launch or hold an edge, then give n carrier ticks three clocks apart
  task automatic do_edge(input logic m, input int n);
    mod_req <= m;
    repeat (2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      carrier_tick <= 1'b1;
      @(posedge clk);
      carrier_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    @(negedge clk);
    @(posedge clk);
  endtask

  // ==========================================================
  // scenario: reset values, masks, unmapped place, 424k outputs
  task automatic t_regs();
    logic [7:0] offs [6];
    logic [7:0] msk [6];
    logic [7:0] d;
    offs = '{OFS_RESID_212, OFS_KIND_212, OFS_PARAM_212, OFS_DUR_212, OFS_RESID_424,
      OFS_KIND_424};
    msk = '{8'hff, 8'hff, PARAM_MASK, DUR_MASK, 8'hff, 8'hff};
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], d);
      chk8("reset value", 8'h00, d);
      wr(offs[i], 8'hff);
      rd(offs[i], d);
      chk8("masked readback", msk[i], d);
      @(negedge clk);
      chk8("rdata after read", 8'h00, rdata);
    end
    chk8("residual 424k out", AMP_FULL, residual_level_424k);
    wr(OFS_RESID_424, 8'h00);
    wr(OFS_KIND_424, 8'h5a);
    @(negedge clk);
    chk8("residual 424k zero", 8'h00, residual_level_424k);
    chk8("kind 424k out", 8'h5a, shape_kind_424k);
    wr(8'h05, 8'hff);
    rd(8'h05, d);
    chk8("unmapped read", 8'h00, d);
    $display("test regs done");
  endtask

  // ==========================================================
  // scenario: firmware ramps of all three styles on both edges
  task automatic t_fw();
    logic [3:0] k;
    logic [7:0] d;
    logic [7:0] fmid [3];
    logic [7:0] rmid [3];
    // levels after three of four states, step 0xbf>>3, halved past mid edge
    fmid = '{8'hba, 8'hc6, 8'hc6};
    rmid = '{8'h85, 8'h79, 8'h79};
    wr(OFS_RESID_212, 8'h40);
    wr(OFS_PARAM_212, 8'h33);
    wr(OFS_DUR_212, 8'h04);
    for (int i = 1; i <= 3; i++) begin
      k = 4'(i);
      wr(OFS_KIND_212, {k, k});
      do_edge(1'b1, 3);
      chk1("fall still active", 1'b1, edge_active);
      chk8("fall mid level", fmid[i-1], amplitude);
      rd(OFS_STATUS, d);
      chk8("fall status", {1'b1, 2'(ST_FALL), 5'h03}, d);
      @(posedge clk);
      do_edge(1'b1, 1);
      chk8("fall lands on residual", 8'h40, amplitude);
      chk1("fall done", 1'b0, edge_active);
      do_edge(1'b0, 3);
      chk1("rise still active", 1'b1, edge_active);
      chk8("rise mid level", rmid[i-1], amplitude);
      rd(OFS_STATUS, d);
      chk8("rise status", {1'b1, 2'(ST_RISE), 5'h03}, d);
      @(posedge clk);
      do_edge(1'b0, 1);
      chk8("rise lands on full", AMP_FULL, amplitude);
      chk1("rise done", 1'b0, edge_active);
    end
    $display("test firmware ramps done");
  endtask

  // ==========================================================
  // scenario: stretch doubles each state, reserved bits ignored
  task automatic t_stretch();
    wr(OFS_KIND_212, 8'h11);
    wr(OFS_DUR_212, 8'he2);
    do_edge(1'b1, 2);
    chk1("stretched fall active", 1'b1, edge_active);
    do_edge(1'b1, 2);
    chk8("stretched fall level", 8'h40, amplitude);
    chk1("stretched fall done", 1'b0, edge_active);
    do_edge(1'b0, 4);
    chk8("stretched rise level", AMP_FULL, amplitude);
    $display("test stretch done");
  endtask

  // ==========================================================
  // scenario: reserved kind codes jump without ramp
  task automatic t_reserved();
    wr(OFS_KIND_212, 8'h77);
    wr(OFS_DUR_212, 8'h02);
    do_edge(1'b1, 0);
    chk8("reserved fall jump", 8'h40, amplitude);
    chk1("reserved fall idle", 1'b0, edge_active);
    do_edge(1'b0, 0);
    chk8("reserved rise jump", AMP_FULL, amplitude);
    $display("test reserved codes done");
  endtask

  // ==========================================================
  // scenario: table ramps, table select and supply adaptation
  task automatic t_lut();
    logic [7:0] kinds [5];
    logic [7:0] prm [5];
    logic [7:0] fall_exp [5];
    logic [7:0] rise_exp [5];
    logic [7:0] d;
    kinds = '{8'h41, 8'h51, 8'h61, 8'h41, 8'h14};
    prm = '{8'h22, 8'h22, 8'h22, 8'h02, 8'h02};
    fall_exp = '{8'hdf, 8'h7f, 8'hef, 8'hff, 8'h7f};
    rise_exp = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h9f};
    // table 0 holds zero fractions, table 2 a quarter
    wr(OFS_LUT_INDEX, 8'h00);
    wr(OFS_LUT_DATA, 8'h00);
    wr(OFS_LUT_DATA, 8'h00);
    wr(OFS_LUT_INDEX, 8'h40);
    wr(OFS_LUT_DATA, 8'h40);
    wr(OFS_LUT_DATA, 8'h40);
    wr(OFS_RESID_212, 8'h7f);
    wr(OFS_DUR_212, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_KIND_212, kinds[i]);
      wr(OFS_PARAM_212, prm[i]);
      do_edge(1'b1, 1);
      chk8("table fall level", fall_exp[i], amplitude);
      do_edge(1'b0, 1);
      chk8("table rise level", rise_exp[i], amplitude);
    end
    // two data writes after pointing at table 2 entry 0
    rd(OFS_LUT_INDEX, d);
    chk8("table index after loads", 8'h42, d);
    $display("test table ramps done");
  endtask

  // ==========================================================
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_fw();
    t_stretch();
    t_reserved();
    t_lut();
    finish_test();
  end

endmodule // tes_top_tb
